//--- usb3_phy_tuning_override_regs.sv
// Override bank for SuperSpeed PHY transmit swing, de-emphasis and
// receiver equalization of up to four ports, in configuration space.
// Assumes a one-cycle configuration request strobe on i_core_clk and
// built-in default settings supplied as levels per port.
`timescale 1ns/1ns
module usb3_phy_tuning_override_regs
    import phy_tuning_pkg::*;
#(
    parameter int PORT_COUNT = 4
) (
    // Clock and resets
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_link_side_reset,
    input wire logic i_global_chip_reset,
    // Configuration access
    input wire logic i_cfg_req,
    input wire logic i_cfg_write,
    input wire logic [CFG_ADDR_W-1:0] i_cfg_addr,
    input wire logic [CFG_BE_W-1:0] i_cfg_be,
    input wire logic [CFG_DATA_W-1:0] i_cfg_wdata,
    output logic o_cfg_ack,
    output logic [CFG_DATA_W-1:0] o_cfg_rdata,
    // Built-in settings per port, port 1 at index 0
    input wire phy_tuning_s [MAX_PORTS-1:0] i_default_tuning,
    // Settings presented to the PHY lanes, port 1 at index 0
    output phy_tuning_s [MAX_PORTS-1:0] o_phy_tuning
);

    // Address match, shared by the write and read paths
    function automatic logic hits(input logic [CFG_ADDR_W-1:0] addr,
                                  input logic [CFG_ADDR_W-1:0] offset);
        hits = (addr[CFG_ADDR_W-1:2] == offset[CFG_ADDR_W-1:2]);
    endfunction

    // Byte-enable merge of a write into a stored word
    function automatic logic [CFG_DATA_W-1:0] merge_bytes(
        input logic [CFG_DATA_W-1:0] old_word,
        input logic [CFG_DATA_W-1:0] new_word,
        input logic [CFG_BE_W-1:0] be);
        logic [CFG_DATA_W-1:0] result;
        result = old_word;
        for (int b = 0; b < CFG_BE_W; b++) begin
            if (be[b]) begin
                result[b*8 +: 8] = new_word[b*8 +: 8];
            end
        end
        merge_bytes = result;
    endfunction

    // Four-bit field taken from a register word
    function automatic logic [FIELD_W-1:0] field_at(input logic [CFG_DATA_W-1:0] word,
                                                    input int lsb);
        field_at = word[lsb +: FIELD_W];
    endfunction

    cfg_req_s cfg;
    bank_state_s state_q;
    bank_state_s state_d;
    logic bank_reset;
    logic write_amp_emph;
    logic write_equalizer;
    logic write_replace;
    phy_tuning_s [MAX_PORTS-1:0] programmed;
    replace_s [MAX_PORTS-1:0] replace;

    // Request gathered into one carrier
    assign cfg.req = i_cfg_req;
    assign cfg.write = i_cfg_write;
    assign cfg.addr = i_cfg_addr;
    assign cfg.be = i_cfg_be;
    assign cfg.wdata = i_cfg_wdata;

    // Link, global and power-on resets act alike
    reset_merge u_reset_merge (
        .i_power_on_reset(i_reset),
        .i_link_side_reset(i_link_side_reset),
        .i_global_chip_reset(i_global_chip_reset),
        .o_bank_reset(bank_reset)
    );

    // Write strobes per register
    assign write_amp_emph = cfg.req & cfg.write & hits(cfg.addr, AMP_EMPH_OFFSET);
    assign write_equalizer = cfg.req & cfg.write & hits(cfg.addr, EQUALIZER_OFFSET);
    assign write_replace = cfg.req & cfg.write & hits(cfg.addr, REPLACE_OFFSET);

    // Next state: register writes, read capture and acknowledge
    always_comb begin
        state_d = state_q;
        state_d.ack = cfg.req;
        if (write_amp_emph) begin
            state_d.amp_emph = merge_bytes(state_q.amp_emph, cfg.wdata, cfg.be);
        end
        if (write_equalizer) begin
            state_d.equalizer = merge_bytes(state_q.equalizer, cfg.wdata, cfg.be);
        end
        if (write_replace) begin
            state_d.replace = merge_bytes(state_q.replace, cfg.wdata, cfg.be)
                              & REPLACE_WRITABLE;
        end
        if (cfg.req && !cfg.write) begin
            if (hits(cfg.addr, AMP_EMPH_OFFSET)) begin
                state_d.rdata = state_q.amp_emph;
            end else if (hits(cfg.addr, EQUALIZER_OFFSET)) begin
                state_d.rdata = state_q.equalizer;
            end else if (hits(cfg.addr, REPLACE_OFFSET)) begin
                state_d.rdata = state_q.replace & REPLACE_WRITABLE;
            end else begin
                state_d.rdata = UNMAPPED_READ;
            end
        end
    end

    // State register with merged synchronous reset
    always_ff @(posedge i_core_clk) begin
        if (bank_reset) begin
            state_q.amp_emph <= AMP_EMPH_RESET;
            state_q.equalizer <= EQUALIZER_RESET;
            state_q.replace <= REPLACE_RESET;
            state_q.rdata <= UNMAPPED_READ;
            state_q.ack <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // Access answer straight from flip-flops
    assign o_cfg_ack = state_q.ack;
    assign o_cfg_rdata = state_q.rdata;

    // Programmed port 4 values
    assign programmed[3].eq_initial = field_at(state_q.equalizer, P4_EQ_INIT_LSB);
    assign programmed[3].eq_functional = field_at(state_q.equalizer, P4_EQ_FUNC_LSB);
    assign programmed[3].tx_amplitude = field_at(state_q.amp_emph, P4_AMP_LSB);
    assign programmed[3].emphasis = field_at(state_q.amp_emph, P4_EMPH_LSB);

    // Programmed port 3 values
    assign programmed[2].eq_initial = field_at(state_q.equalizer, P3_EQ_INIT_LSB);
    assign programmed[2].eq_functional = field_at(state_q.equalizer, P3_EQ_FUNC_LSB);
    assign programmed[2].tx_amplitude = field_at(state_q.amp_emph, P3_AMP_LSB);
    assign programmed[2].emphasis = field_at(state_q.amp_emph, P3_EMPH_LSB);

    // Programmed port 2 values
    assign programmed[1].eq_initial = field_at(state_q.equalizer, P2_EQ_INIT_LSB);
    assign programmed[1].eq_functional = field_at(state_q.equalizer, P2_EQ_FUNC_LSB);
    assign programmed[1].tx_amplitude = field_at(state_q.amp_emph, P2_AMP_LSB);
    assign programmed[1].emphasis = field_at(state_q.amp_emph, P2_EMPH_LSB);

    // Programmed port 1 values
    assign programmed[0].eq_initial = field_at(state_q.equalizer, P1_EQ_INIT_LSB);
    assign programmed[0].eq_functional = field_at(state_q.equalizer, P1_EQ_FUNC_LSB);
    assign programmed[0].tx_amplitude = field_at(state_q.amp_emph, P1_AMP_LSB);
    assign programmed[0].emphasis = field_at(state_q.amp_emph, P1_EMPH_LSB);

    // Port 4 override selectors
    assign replace[3].equalization = state_q.replace[P4_EQ_REPLACE_BIT];
    assign replace[3].tx_amplitude = state_q.replace[P4_AMP_REPLACE_BIT];
    assign replace[3].emphasis = state_q.replace[P4_EMPH_REPLACE_BIT];

    // Port 3 override selectors
    assign replace[2].equalization = state_q.replace[P3_EQ_REPLACE_BIT];
    assign replace[2].tx_amplitude = state_q.replace[P3_AMP_REPLACE_BIT];
    assign replace[2].emphasis = state_q.replace[P3_EMPH_REPLACE_BIT];

    // Port 2 override selectors
    assign replace[1].equalization = state_q.replace[P2_EQ_REPLACE_BIT];
    assign replace[1].tx_amplitude = state_q.replace[P2_AMP_REPLACE_BIT];
    assign replace[1].emphasis = state_q.replace[P2_EMPH_REPLACE_BIT];

    // Port 1 override selectors
    assign replace[0].equalization = state_q.replace[P1_EQ_REPLACE_BIT];
    assign replace[0].tx_amplitude = state_q.replace[P1_AMP_REPLACE_BIT];
    assign replace[0].emphasis = state_q.replace[P1_EMPH_REPLACE_BIT];

    // One selector per port; absent ports keep their defaults
    for (genvar p = 0; p < MAX_PORTS; p++) begin : g_port
        tuning_select u_tuning_select (
            .i_default(i_default_tuning[p]),
            .i_programmed(programmed[p]),
            .i_replace(replace[p]),
            .i_port_present(p < PORT_COUNT),
            .o_selected(o_phy_tuning[p])
        );
    end

endmodule

//--- phy_tuning_pkg.sv
// Shared constants and carrier types for the PHY tuning override bank.
// Assumes byte offsets in configuration space and 4-bit tuning fields.
package phy_tuning_pkg;

    // Ports and field geometry
    localparam int MAX_PORTS = 4;
    localparam int FIELD_W = 4;
    localparam int CFG_ADDR_W = 12;
    localparam int CFG_DATA_W = 32;
    localparam int CFG_BE_W = CFG_DATA_W / 8;

    // Register byte offsets
    localparam logic [CFG_ADDR_W-1:0] AMP_EMPH_OFFSET = 12'h0e4;
    localparam logic [CFG_ADDR_W-1:0] EQUALIZER_OFFSET = 12'h0e8;
    localparam logic [CFG_ADDR_W-1:0] REPLACE_OFFSET = 12'h0ec;

    // Reset values
    localparam logic [CFG_DATA_W-1:0] AMP_EMPH_RESET = 32'h0000_0000;
    localparam logic [CFG_DATA_W-1:0] EQUALIZER_RESET = 32'h0000_0000;
    localparam logic [CFG_DATA_W-1:0] REPLACE_RESET = 32'h0000_0000;
    localparam logic [CFG_DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

    // Only implemented bits of the override register can hold a one
    localparam logic [CFG_DATA_W-1:0] REPLACE_WRITABLE = 32'h0707_0707;

    // Swing and de-emphasis register field positions
    localparam int P4_AMP_LSB = 28;
    localparam int P4_EMPH_LSB = 24;
    localparam int P3_AMP_LSB = 20;
    localparam int P3_EMPH_LSB = 16;
    localparam int P2_AMP_LSB = 12;
    localparam int P2_EMPH_LSB = 8;
    localparam int P1_AMP_LSB = 4;
    localparam int P1_EMPH_LSB = 0;

    // Equalizer register field positions
    localparam int P4_EQ_INIT_LSB = 28;
    localparam int P4_EQ_FUNC_LSB = 24;
    localparam int P3_EQ_INIT_LSB = 20;
    localparam int P3_EQ_FUNC_LSB = 16;
    localparam int P2_EQ_INIT_LSB = 12;
    localparam int P2_EQ_FUNC_LSB = 8;
    localparam int P1_EQ_INIT_LSB = 4;
    localparam int P1_EQ_FUNC_LSB = 0;

    // Override register bit positions
    localparam int P4_EQ_REPLACE_BIT = 26;
    localparam int P4_AMP_REPLACE_BIT = 25;
    localparam int P4_EMPH_REPLACE_BIT = 24;
    localparam int P3_EQ_REPLACE_BIT = 18;
    localparam int P3_AMP_REPLACE_BIT = 17;
    localparam int P3_EMPH_REPLACE_BIT = 16;
    localparam int P2_EQ_REPLACE_BIT = 10;
    localparam int P2_AMP_REPLACE_BIT = 9;
    localparam int P2_EMPH_REPLACE_BIT = 8;
    localparam int P1_EQ_REPLACE_BIT = 2;
    localparam int P1_AMP_REPLACE_BIT = 1;
    localparam int P1_EMPH_REPLACE_BIT = 0;

    // One port's set of PHY lane controls
    typedef struct packed {
        logic [FIELD_W-1:0] tx_amplitude;
        logic [FIELD_W-1:0] emphasis;
        logic [FIELD_W-1:0] eq_initial;
        logic [FIELD_W-1:0] eq_functional;
    } phy_tuning_s;

    // One port's override selectors
    typedef struct packed {
        logic equalization;
        logic tx_amplitude;
        logic emphasis;
    } replace_s;

    // Configuration access request
    typedef struct packed {
        logic req;
        logic write;
        logic [CFG_ADDR_W-1:0] addr;
        logic [CFG_BE_W-1:0] be;
        logic [CFG_DATA_W-1:0] wdata;
    } cfg_req_s;

    // All state of the register bank
    typedef struct packed {
        logic [CFG_DATA_W-1:0] amp_emph;
        logic [CFG_DATA_W-1:0] equalizer;
        logic [CFG_DATA_W-1:0] replace;
        logic [CFG_DATA_W-1:0] rdata;
        logic ack;
    } bank_state_s;

endpackage

//--- reset_merge.sv
// Merges the three reset sources of the tuning bank into one.
// Assumes every source is a synchronous active-high level.
`timescale 1ns/1ns
module reset_merge (
    // Reset sources
    input wire logic i_power_on_reset,
    input wire logic i_link_side_reset,
    input wire logic i_global_chip_reset,
    // Merged reset
    output logic o_bank_reset
);

    // Any source clears the bank at the same edge
    assign o_bank_reset = i_power_on_reset | i_link_side_reset | i_global_chip_reset;

endmodule

//--- tuning_select.sv
// Chooses between built-in and programmed tuning for one port.
// Assumes both candidates are stable levels; purely combinational.
`timescale 1ns/1ns
module tuning_select
    import phy_tuning_pkg::*;
(
    // Candidate settings
    input wire phy_tuning_s i_default,
    input wire phy_tuning_s i_programmed,
    // Selection control
    input wire replace_s i_replace,
    input wire logic i_port_present,
    // Setting presented to the PHY lane
    output phy_tuning_s o_selected
);

    replace_s effective;

    // Absent ports never leave their built-in settings
    assign effective.equalization = i_replace.equalization & i_port_present;
    assign effective.tx_amplitude = i_replace.tx_amplitude & i_port_present;
    assign effective.emphasis = i_replace.emphasis & i_port_present;

    // Per-parameter choice
    always_comb begin
        o_selected = i_default;
        if (effective.equalization) begin
            o_selected.eq_initial = i_programmed.eq_initial;
            o_selected.eq_functional = i_programmed.eq_functional;
        end
        if (effective.tx_amplitude) begin
            o_selected.tx_amplitude = i_programmed.tx_amplitude;
        end
        if (effective.emphasis) begin
            o_selected.emphasis = i_programmed.emphasis;
        end
    end

endmodule

//--- phy_lane_model.sv
// Far-side PHY lane model: built-in defaults out, applied settings in.
// Assumes lanes take their settings as levels on the core clock.
`timescale 1ns/1ns
module phy_lane_model
    import phy_tuning_pkg::*;
#(
    parameter logic [15:0] DEFAULT_BASE = 16'hc3a5
) (
    // Clock
    input wire logic i_core_clk,
    // Settings from the bank
    input wire phy_tuning_s [MAX_PORTS-1:0] i_tuning,
    // Built-in defaults and applied settings
    output phy_tuning_s [MAX_PORTS-1:0] o_default,
    output phy_tuning_s [MAX_PORTS-1:0] o_applied
);
    // Distinct defaults per port so a wrong pick shows
    always_comb begin
        for (int k = 0; k < MAX_PORTS; k++) begin
            o_default[k] = DEFAULT_BASE ^ {4{4'(k)}};
        end
    end
    // Lanes take their settings each clock
    always_ff @(posedge i_core_clk) begin
        o_applied <= i_tuning;
    end
endmodule

//--- tuning_bank_props.sv
// Port checks for the tuning override bank.
// Assumes binding to every bank instance; shadows follow the writes.
`timescale 1ns/1ns
module tuning_bank_props
    import phy_tuning_pkg::*;
#(
    parameter int PORT_COUNT = 4
) (
    // Clock and resets
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_link_side_reset,
    input wire logic i_global_chip_reset,
    // Configuration access
    input wire logic i_cfg_req,
    input wire logic i_cfg_write,
    input wire logic [CFG_ADDR_W-1:0] i_cfg_addr,
    input wire logic [CFG_BE_W-1:0] i_cfg_be,
    input wire logic [CFG_DATA_W-1:0] i_cfg_wdata,
    input wire logic o_cfg_ack,
    input wire logic [CFG_DATA_W-1:0] o_cfg_rdata,
    // PHY settings
    input wire phy_tuning_s [MAX_PORTS-1:0] i_default_tuning,
    input wire phy_tuning_s [MAX_PORTS-1:0] o_phy_tuning
);
    logic rst_any;
    logic wr_ok;
    logic [31:0] msk;
    logic [31:0] ae_q;
    logic [31:0] eq_q;
    logic [31:0] ov_q;
    // Merged reset and byte mask
    assign rst_any = i_reset | i_link_side_reset | i_global_chip_reset;
    assign wr_ok = i_cfg_req & i_cfg_write;
    assign msk = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
    // Shadow registers
    always_ff @(posedge i_core_clk) begin
        if (rst_any) begin
            ae_q <= '0;
            eq_q <= '0;
            ov_q <= '0;
        end else if (wr_ok && i_cfg_addr[11:2] == AMP_EMPH_OFFSET[11:2]) begin
            ae_q <= (ae_q & ~msk) | (i_cfg_wdata & msk);
        end else if (wr_ok && i_cfg_addr[11:2] == EQUALIZER_OFFSET[11:2]) begin
            eq_q <= (eq_q & ~msk) | (i_cfg_wdata & msk);
        end else if (wr_ok && i_cfg_addr[11:2] == REPLACE_OFFSET[11:2]) begin
            ov_q <= (ov_q & ~msk) | (i_cfg_wdata & msk);
        end
    end
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (rst_any);
    // Read of the override register, then its answer
    sequence s_ov_read;
        i_cfg_req && !i_cfg_write && i_cfg_addr[11:2] == REPLACE_OFFSET[11:2];
    endsequence
    sequence s_answer;
        o_cfg_ack;
    endsequence
    property p_ack; i_cfg_req |=> o_cfg_ack; endproperty
    property p_no_ack; !i_cfg_req |=> !o_cfg_ack; endproperty
    property p_resv; s_ov_read ##1 s_answer |-> (o_cfg_rdata & ~REPLACE_WRITABLE) == '0;
    endproperty
    property p_rst; $fell(rst_any) |-> o_phy_tuning == i_default_tuning
        && !o_cfg_ack && o_cfg_rdata == '0; endproperty
    property p_p1_eq; o_phy_tuning[0].eq_initial ==
        (ov_q[2] ? eq_q[7:4] : i_default_tuning[0].eq_initial); endproperty
    property p_p2_amp; o_phy_tuning[1].tx_amplitude ==
        (ov_q[9] ? ae_q[15:12] : i_default_tuning[1].tx_amplitude); endproperty
    property p_p3_emph; o_phy_tuning[2].emphasis ==
        ((PORT_COUNT > 2 && ov_q[16]) ? ae_q[19:16] : i_default_tuning[2].emphasis); endproperty
    property p_p4_eq; o_phy_tuning[3].eq_functional ==
        ((PORT_COUNT > 3 && ov_q[26]) ? eq_q[27:24] : i_default_tuning[3].eq_functional);
    endproperty
    a_ack: assert property (p_ack) else $error("request not answered");
    a_no_ack: assert property (p_no_ack) else $error("answer without request");
    a_resv: assert property (p_resv) else $error("unused override bit read one");
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
    a_p1_eq: assert property (p_p1_eq) else $error("port 1 eq wrong");
    a_p2_amp: assert property (p_p2_amp) else $error("port 2 swing wrong");
    a_p3_emph: assert property (p_p3_emph) else $error("port 3 emph wrong");
    a_p4_eq: assert property (p_p4_eq) else $error("port 4 eq wrong");
endmodule
bind usb3_phy_tuning_override_regs tuning_bank_props #(.PORT_COUNT(PORT_COUNT)) props_u (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_link_side_reset(i_link_side_reset),
    .i_global_chip_reset(i_global_chip_reset), .i_cfg_req(i_cfg_req),
    .i_cfg_write(i_cfg_write), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
    .i_cfg_wdata(i_cfg_wdata), .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata),
    .i_default_tuning(i_default_tuning), .o_phy_tuning(o_phy_tuning));

//--- tb_top.sv
// Bench for the tuning bank, four-port and two-port side by side.
// Assumes 10 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ns
module tb_top;
    import phy_tuning_pkg::*;
    localparam logic [31:0] AE_VAL = 32'h1357_9bdf;
    localparam logic [31:0] EQ_VAL = 32'h2468_ace0;
    logic i_core_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_link_side_reset = 1'b0;
    logic i_global_chip_reset = 1'b0;
    logic i_cfg_req = 1'b0;
    logic i_cfg_write = 1'b0;
    logic [CFG_ADDR_W-1:0] i_cfg_addr = '0;
    logic [CFG_BE_W-1:0] i_cfg_be = '0;
    logic [CFG_DATA_W-1:0] i_cfg_wdata = '0;
    logic ack4;
    logic ack2;
    logic [CFG_DATA_W-1:0] rd4;
    logic [CFG_DATA_W-1:0] rd2;
    phy_tuning_s [MAX_PORTS-1:0] defaults;
    phy_tuning_s [MAX_PORTS-1:0] out4;
    phy_tuning_s [MAX_PORTS-1:0] out2;
    phy_tuning_s [MAX_PORTS-1:0] applied;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    // Four-port bank, two-port bank and the lanes
    usb3_phy_tuning_override_regs #(.PORT_COUNT(4)) dut_u (.i_core_clk(i_core_clk),
        .i_reset(i_reset), .i_link_side_reset(i_link_side_reset),
        .i_global_chip_reset(i_global_chip_reset), .i_cfg_req(i_cfg_req),
        .i_cfg_write(i_cfg_write), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
        .i_cfg_wdata(i_cfg_wdata), .o_cfg_ack(ack4), .o_cfg_rdata(rd4),
        .i_default_tuning(defaults), .o_phy_tuning(out4));
    usb3_phy_tuning_override_regs #(.PORT_COUNT(2)) dut2_u (.i_core_clk(i_core_clk),
        .i_reset(i_reset), .i_link_side_reset(i_link_side_reset),
        .i_global_chip_reset(i_global_chip_reset), .i_cfg_req(i_cfg_req),
        .i_cfg_write(i_cfg_write), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
        .i_cfg_wdata(i_cfg_wdata), .o_cfg_ack(ack2), .o_cfg_rdata(rd2),
        .i_default_tuning(defaults), .o_phy_tuning(out2));
    phy_lane_model model_u (.i_core_clk(i_core_clk), .i_tuning(out4),
        .o_default(defaults), .o_applied(applied));
    // Clock and hang guard
    initial begin
        forever #50 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cmp_word(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_tuning(string what, phy_tuning_s exp, phy_tuning_s got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Expected lane setting with the programmed words in place
    function automatic phy_tuning_s exp_port(int k, logic [31:0] ov, int pc);
        phy_tuning_s e;
        e = defaults[k];
        if (k < pc && ov[8*k+1]) e.tx_amplitude = AE_VAL[8*k+4+:4];
        if (k < pc && ov[8*k]) e.emphasis = AE_VAL[8*k+:4];
        if (k < pc && ov[8*k+2]) e.eq_initial = EQ_VAL[8*k+4+:4];
        if (k < pc && ov[8*k+2]) e.eq_functional = EQ_VAL[8*k+:4];
        return e;
    endfunction
    // One access: request for one cycle, answer seen the cycle after
    task automatic cfg(logic wr, logic [11:0] a, logic [3:0] be, logic [31:0] d);
        @(negedge i_core_clk);
        {i_cfg_req, i_cfg_write, i_cfg_addr, i_cfg_be, i_cfg_wdata} = {1'b1, wr, a, be, d};
        @(negedge i_core_clk);
        i_cfg_req = 1'b0;
        cmp_word("ack", 32'h1, {31'h0, ack4 & ack2});
    endtask
    task automatic check_read(logic [11:0] a, logic [31:0] exp4, logic [31:0] exp2);
        cfg(1'b0, a, 4'hf, 32'h0);
        cmp_word("rdata4", exp4, rd4);
        cmp_word("rdata2", exp2, rd2);
    endtask
    task automatic check_outputs(logic [31:0] ov);
        // Lanes latch the settings one edge later
        @(negedge i_core_clk);
        for (int k = 0; k < MAX_PORTS; k++) begin
            cmp_tuning("lane4", exp_port(k, ov, 4), out4[k]);
            cmp_tuning("lane2", exp_port(k, ov, 2), out2[k]);
            cmp_tuning("applied", exp_port(k, ov, 4), applied[k]);
        end
    endtask
    // Each override bit alone steers only its own field
    task automatic t_each_bit();
        logic [31:0] ov;
        cfg(1'b1, AMP_EMPH_OFFSET, 4'hf, AE_VAL);
        cfg(1'b1, EQUALIZER_OFFSET, 4'hf, EQ_VAL);
        check_read(AMP_EMPH_OFFSET, AE_VAL, AE_VAL);
        check_read(EQUALIZER_OFFSET, EQ_VAL, EQ_VAL);
        for (int b = 0; b < 12; b++) begin
            ov = 32'h1 << (8 * (b / 3) + b % 3);
            cfg(1'b1, REPLACE_OFFSET, 4'hf, ov);
            check_outputs(ov);
        end
    endtask
    // Unused bits, byte enables and an unmapped offset
    task automatic t_reserved();
        cfg(1'b1, REPLACE_OFFSET, 4'hf, 32'hffff_ffff);
        check_read(REPLACE_OFFSET, 32'h0707_0707, 32'h0707_0707);
        check_outputs(32'h0707_0707);
        cfg(1'b1, REPLACE_OFFSET, 4'h2, 32'h0);
        check_read(REPLACE_OFFSET, 32'h0707_0007, 32'h0707_0007);
        cfg(1'b1, 12'h0f0, 4'hf, 32'hffff_ffff);
        check_read(12'h0f0, 32'h0, 32'h0);
        check_read(AMP_EMPH_OFFSET, AE_VAL, AE_VAL);
    endtask
    // Every reset source clears all three registers
    task automatic t_resets();
        for (int r = 0; r < 3; r++) begin
            cfg(1'b1, REPLACE_OFFSET, 4'hf, 32'hffff_ffff);
            cfg(1'b1, EQUALIZER_OFFSET, 4'hf, EQ_VAL);
            cfg(1'b1, AMP_EMPH_OFFSET, 4'hf, AE_VAL);
            @(negedge i_core_clk);
            {i_global_chip_reset, i_link_side_reset, i_reset} = 3'(1 << r);
            @(negedge i_core_clk);
            {i_global_chip_reset, i_link_side_reset, i_reset} = 3'h0;
            check_read(REPLACE_OFFSET, 32'h0, 32'h0);
            check_read(EQUALIZER_OFFSET, 32'h0, 32'h0);
            check_read(AMP_EMPH_OFFSET, 32'h0, 32'h0);
            check_outputs(32'h0);
        end
    endtask
    // Main sequence
    initial begin
        repeat (5) @(negedge i_core_clk);
        i_reset = 1'b0;
        check_read(REPLACE_OFFSET, REPLACE_RESET, REPLACE_RESET);
        check_outputs(32'h0);
        t_each_bit();
        t_reserved();
        t_resets();
        report_and_stop();
    end
endmodule
